// file: hdl/wiper_pkg.sv
// package: constants and types for the push button wiper block
package wiper_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned DEBOUNCE_MS = 8;
   localparam int unsigned SCAN_START_MS = 1000;
   localparam int unsigned SCAN_STEP_MS = 140;
   localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS + 1;
   localparam int unsigned SCAN_START_CYC = (CLK_HZ / 1000) * SCAN_START_MS + 1;
   localparam int unsigned SCAN_STEP_CYC = (CLK_HZ / 1000) * SCAN_STEP_MS;
   localparam int unsigned CODE_W = 6;
   localparam int unsigned TAPS = 64;
   localparam logic [5:0] CODE_RESET = 6'h20;
   typedef enum logic [1:0] {POS_CODE, POS_BOTTOM, POS_TOP} pos_t;
endpackage

// file: hdl/step_if.sv
// interface: one debounced step request channel
`timescale 1ns/1ps
interface step_if;
   logic held;
   logic step;
   modport src (output held, output step);
   modport dst (input held, input step);
endinterface

// file: hdl/button_timer.sv
// module: debounce and auto scan timing for one button
`timescale 1ns/1ps
module button_timer #(
   parameter int unsigned DEB_CYC = wiper_pkg::DEBOUNCE_CYC,
   parameter int unsigned START_CYC = wiper_pkg::SCAN_START_CYC,
   parameter int unsigned STEP_CYC = wiper_pkg::SCAN_STEP_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // raw button pin
   input wire logic button_in,
   // step requests
   step_if.src req
);
   logic [2:0] sync_r;
   logic level_r;
   logic [31:0] cnt_r;
   logic [31:0] scan_r;
   logic fired_r;
   logic scanning_r;

   // ---------------------------------
   // three stage synchroniser
   // ---------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync_r <= 3'h0;
         level_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], button_in};
         if (sync_r[1] == sync_r[2]) begin
            level_r <= sync_r[2];
         end
      end
   end

   // ---------------------------------
   // high time counter, cleared on level change
   // ---------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_r <= 32'h0;
      end else if (!level_r) begin
         cnt_r <= 32'h0;
      end else if (cnt_r < START_CYC) begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fired_r <= 1'b0;
         scanning_r <= 1'b0;
         scan_r <= 32'h0;
      end else if (!level_r) begin
         fired_r <= 1'b0;
         scanning_r <= 1'b0;
         scan_r <= 32'h0;
      end else begin
         if (cnt_r == DEB_CYC) begin
            fired_r <= 1'b1;
         end
         if (cnt_r == START_CYC) begin
            scanning_r <= 1'b1;
         end
         if (scanning_r) begin
            scan_r <= (scan_r == STEP_CYC - 1) ? 32'h0 : scan_r + 32'h1;
         end
      end
   end

   // one step at the debounce mark, then one per scan period
   assign req.step = level_r && ((cnt_r == DEB_CYC) || (scanning_r && scan_r == STEP_CYC - 1));
   assign req.held = level_r && (fired_r || cnt_r == DEB_CYC);
endmodule // button_timer

// file: hdl/wiper_end_scale.sv
// module: wiper code, end scale states and end scale indicator
//
// Behaviour
// - auto save enabled: indicator pin shows end state while a button is held
// - autosave on, end state plus active button drives indicator high
// - indicator drops when buttons released or end is left
// - 6-bit code decoded to one-hot 64 taps
// - bottom and top scale beyond code range
// - higher code moves tap toward A end
// - ignore pulses under 8 ms, step once
// - held over 1 s: step every 140 ms
// - indicator pin sampled at power up, low enables
// - no stepping past bottom or top scale
`timescale 1ns/1ps
module wiper_end_scale #(
   parameter int unsigned DEB_CYC = wiper_pkg::DEBOUNCE_CYC,
   parameter int unsigned START_CYC = wiper_pkg::SCAN_START_CYC,
   parameter int unsigned STEP_CYC = wiper_pkg::SCAN_STEP_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // push buttons
   input wire logic step_up_button_in,
   input wire logic step_down_button_in,
   // autosave enable / end scale indicator pin
   input wire logic autosave_enable_indicator_in,
   output logic autosave_enable_indicator_out,
   output logic autosave_enable_indicator_oe_out,
   // wiper state
   output logic [wiper_pkg::CODE_W-1:0] wiper_code_out,
   output logic [wiper_pkg::TAPS-1:0] tap_select_out,
   output logic top_scale_state_out,
   output logic bottom_scale_state_out,
   output logic autosave_enabled_out
);
   step_if up_req ();
   step_if down_req ();
   logic [2:0] ase_sync_r;
   logic [1:0] fill_r;
   logic sampled_r;
   logic autosave_r;
   logic [5:0] wiper_code_register_r;
   logic [5:0] wiper_code_nxt;
   wiper_pkg::pos_t pos_r;
   wiper_pkg::pos_t pos_nxt;
   logic step_up_go;
   logic step_down_go;
   logic any_held;
   logic at_end_nxt;
   logic indicator_r;
   logic [wiper_pkg::TAPS-1:0] tap_r;

   // ---------------------------------
   // button timing
   // ---------------------------------
   // buttons are assumed low at power on
   button_timer #(
      .DEB_CYC(DEB_CYC),
      .START_CYC(START_CYC),
      .STEP_CYC(STEP_CYC)
   ) up_timer (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .button_in(step_up_button_in),
      .req(up_req.src)
   );
   button_timer #(
      .DEB_CYC(DEB_CYC),
      .START_CYC(START_CYC),
      .STEP_CYC(STEP_CYC)
   ) down_timer (
      .ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in),
      .button_in(step_down_button_in),
      .req(down_req.src)
   );

   // ---------------------------------
   // power-up option sampling
   // ---------------------------------
   // fill count keeps synchroniser reset contents from passing as the pin level
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fill_r <= 2'h0;
      end else if (fill_r != 2'h3) begin
         fill_r <= fill_r + 2'h1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ase_sync_r <= 3'h0;
      end else begin
         ase_sync_r <= {ase_sync_r[1:0], autosave_enable_indicator_in};
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sampled_r <= 1'b0;
         autosave_r <= 1'b0;
      end else if (!sampled_r && fill_r == 2'h3 && ase_sync_r[1] == ase_sync_r[2]) begin
         sampled_r <= 1'b1;
         autosave_r <= !ase_sync_r[2];
      end
   end

   // ---------------------------------
   // step qualification
   // ---------------------------------
   // opposite requests in one cycle cancel; nothing moves before the option is taken
   always_comb begin
      step_up_go = 1'b0;
      step_down_go = 1'b0;
      if (sampled_r && (up_req.step != down_req.step)) begin
         step_up_go = up_req.step;
         step_down_go = down_req.step;
      end
   end

   always_comb begin
      any_held = up_req.held || down_req.held;
   end

   // ---------------------------------
   // next wiper position
   // ---------------------------------
   always_comb begin
      wiper_code_nxt = wiper_code_register_r;
      pos_nxt = pos_r;
      case (pos_r)
         wiper_pkg::POS_CODE: begin
            if (step_up_go) begin
               if (wiper_code_register_r == 6'h3f) begin
                  pos_nxt = wiper_pkg::POS_TOP;
               end else begin
                  wiper_code_nxt = wiper_code_register_r + 6'h1;
               end
            end else if (step_down_go) begin
               if (wiper_code_register_r == 6'h00) begin
                  pos_nxt = wiper_pkg::POS_BOTTOM;
               end else begin
                  wiper_code_nxt = wiper_code_register_r - 6'h1;
               end
            end
         end
         wiper_pkg::POS_BOTTOM: begin
            if (step_up_go) begin
               pos_nxt = wiper_pkg::POS_CODE;
            end
         end
         wiper_pkg::POS_TOP: begin
            if (step_down_go) begin
               pos_nxt = wiper_pkg::POS_CODE;
            end
         end
         default: begin
            pos_nxt = wiper_pkg::POS_CODE;
         end
      endcase
   end

   // ---------------------------------
   // wiper code and position registers
   // ---------------------------------
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wiper_code_register_r <= wiper_pkg::CODE_RESET;
      end else begin
         wiper_code_register_r <= wiper_code_nxt;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pos_r <= wiper_pkg::POS_CODE;
      end else begin
         pos_r <= pos_nxt;
      end
   end

   // ---------------------------------
   // end scale indicator
   // ---------------------------------
   // next position used so the pin drops on the edge that leaves the end
   always_comb begin
      at_end_nxt = (pos_nxt != wiper_pkg::POS_CODE);
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         indicator_r <= 1'b0;
      end else begin
         // high while autosave enabled, at an end and any button active
         indicator_r <= autosave_r && at_end_nxt && any_held;
      end
   end

   // ---------------------------------
   // tap decode, one flop per tap
   // ---------------------------------
   for (genvar t = 0; t < wiper_pkg::TAPS; t++) begin : g_tap
      always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            tap_r[t] <= 1'b0;
         end else begin
            tap_r[t] <= (wiper_code_register_r == 6'(t));
         end
      end
   end

   // ---------------------------------
   // pin drive
   // ---------------------------------
   assign autosave_enable_indicator_out = indicator_r;
   assign autosave_enable_indicator_oe_out = indicator_r;

   // ---------------------------------
   // status outputs
   // ---------------------------------
   assign wiper_code_out = wiper_code_register_r;
   assign tap_select_out = tap_r;
   assign top_scale_state_out = (pos_r == wiper_pkg::POS_TOP);
   assign bottom_scale_state_out = (pos_r == wiper_pkg::POS_BOTTOM);
   assign autosave_enabled_out = autosave_r;
endmodule // wiper_end_scale

// file: tb/ase_pin_model.sv
// model: autosave pin with its external pull resistor
`timescale 1ns/1ps
module ase_pin_model (
   // pull and drive
   input wire logic pull_high_in,
   input wire logic drive_in,
   input wire logic oe_in,
   // pin level
   output logic pin_out
);
   assign pin_out = oe_in ? drive_in : pull_high_in;
endmodule // ase_pin_model

// file: tb/wiper_end_scale_asserts.sv
// checker: wiper code and end scale indicator
`timescale 1ns/1ps
module wiper_end_scale_asserts (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // pins
   input wire logic step_up_button_in,
   input wire logic step_down_button_in,
   input wire logic autosave_enable_indicator_out,
   input wire logic autosave_enable_indicator_oe_out,
   // wiper state
   input wire logic [wiper_pkg::CODE_W-1:0] wiper_code_out,
   input wire logic [wiper_pkg::TAPS-1:0] tap_select_out,
   input wire logic top_scale_state_out,
   input wire logic bottom_scale_state_out,
   input wire logic autosave_enabled_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   a_ind_at_end: assert property (
      autosave_enable_indicator_out |-> autosave_enabled_out && (top_scale_state_out || bottom_scale_state_out))
      else $error("indicator away from end");
   a_ind_release: assert property (
      (!step_up_button_in && !step_down_button_in)[*8] |-> !autosave_enable_indicator_out)
      else $error("indicator without button");
   a_oe_tracks: assert property (
      autosave_enable_indicator_oe_out == autosave_enable_indicator_out) else $error("enable mismatch");
   a_tap_decode: assert property (
      $past(arst_n_in) |-> tap_select_out == (64'h1 << $past(wiper_code_out))) else $error("tap decode");
   a_scale_code: assert property (
      !(top_scale_state_out && bottom_scale_state_out) && (!top_scale_state_out || wiper_code_out == 6'h3f)
      && (!bottom_scale_state_out || wiper_code_out == 6'h00)) else $error("scale state code");
   a_code_single: assert property (
      $changed(wiper_code_out) && $past(arst_n_in) |-> 6'(wiper_code_out - $past(wiper_code_out)) inside {6'h01, 6'h3f})
      else $error("code jump");
   a_no_ghost_step: assert property (
      $changed(wiper_code_out) |-> $past(step_up_button_in, 6) || $past(step_down_button_in, 6))
      else $error("step without button");
   a_top_stays: assert property (
      (!step_down_button_in)[*8] ##0 top_scale_state_out |=> top_scale_state_out) else $error("left top");
endmodule // wiper_end_scale_asserts
bind wiper_end_scale wiper_end_scale_asserts u_wiper_end_scale_asserts (.ref_clk_in(ref_clk_in),
   .arst_n_in(arst_n_in), .step_up_button_in(step_up_button_in), .step_down_button_in(step_down_button_in),
   .autosave_enable_indicator_out(autosave_enable_indicator_out), .wiper_code_out(wiper_code_out),
   .autosave_enable_indicator_oe_out(autosave_enable_indicator_oe_out), .tap_select_out(tap_select_out),
   .top_scale_state_out(top_scale_state_out), .bottom_scale_state_out(bottom_scale_state_out),
   .autosave_enabled_out(autosave_enabled_out));

// file: tb/tb_top.sv
// testbench: push button wiper block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_top;
   logic ref_clk_in, arst_n_in, up, dn, pull_high;
   logic ase_pin, ind, ind_oe, top, bottom, ase_on;
   logic run_seen = 1'b0;
   logic [5:0] code;
   logic [63:0] tap;
   logic [7:0] exp_q[$];
   logic [7:0] prev = 8'h20, now, e;
   int failures = 0, total_checks = 0, i;
   initial begin
      ref_clk_in = 1'b0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   wiper_end_scale #(.DEB_CYC(10), .START_CYC(50), .STEP_CYC(8)) u_wiper_end_scale (.ref_clk_in(ref_clk_in),
      .arst_n_in(arst_n_in), .step_up_button_in(up), .step_down_button_in(dn), .autosave_enable_indicator_in(ase_pin),
      .autosave_enable_indicator_out(ind), .autosave_enable_indicator_oe_out(ind_oe), .wiper_code_out(code),
      .tap_select_out(tap), .top_scale_state_out(top), .bottom_scale_state_out(bottom), .autosave_enabled_out(ase_on));
   ase_pin_model u_ase_pin_model (.pull_high_in(pull_high), .drive_in(ind), .oe_in(ind_oe), .pin_out(ase_pin));
   // ---------------------------------------
   // result watcher
   // ---------------------------------------
   always @(negedge ref_clk_in) begin
      now = {top, bottom, code};
      if (arst_n_in && now !== prev) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hff;
         `CHK("state", e, now)
      end else if (arst_n_in && run_seen) begin
         `CHK("tap", 64'h1 << code, tap)
      end
      prev = now;
      run_seen = arst_n_in;
   end
   task automatic finish_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic hold(input logic u, input logic d, input int n, input logic ind_exp);
      up <= u;
      dn <= d;
      repeat (n) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      `CHK("indicator", ind_exp, ind)
      `CHK("pin", ind_exp | pull_high, ase_pin)
      @(posedge ref_clk_in);
      up <= 1'b0;
      dn <= 1'b0;
      repeat (20) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      `CHK("indicator off", 1'b0, ind)
      `CHK("pin off", pull_high, ase_pin)
      @(posedge ref_clk_in);
   endtask
   // ---------------------------------------
   // main sequence, buttons low at reset
   // ---------------------------------------
   initial begin
      arst_n_in <= 1'b0;
      up <= 1'b0;
      dn <= 1'b0;
      pull_high <= 1'b0;
      void'($urandom(64));
      repeat (6) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      `CHK("autosave", 1'b1, ase_on)
      for (i = 0; i < 8; i++) hold(i[0], !i[0], $urandom % 6 + 1, 1'b0);
      exp_q.push_back(8'h21);
      hold(1'b1, 1'b0, 30, 1'b0);
      for (i = 8'h22; i <= 8'h3f; i++) exp_q.push_back(8'(i));
      exp_q.push_back(8'hbf);
      hold(1'b1, 1'b0, 400, 1'b1);
      exp_q.push_back(8'h3f);
      hold(1'b0, 1'b1, 30, 1'b0);
      for (i = 8'h3e; i >= 0; i--) exp_q.push_back(8'(i));
      exp_q.push_back(8'h40);
      hold(1'b0, 1'b1, 700, 1'b1);
      exp_q.push_back(8'h00);
      hold(1'b1, 1'b0, 30, 1'b0);
      hold(1'b1, 1'b1, 30, 1'b0);
      pull_high <= 1'b1;
      arst_n_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      arst_n_in <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      `CHK("autosave off", 1'b0, ase_on)
      for (i = 8'h1f; i >= 0; i--) exp_q.push_back(8'(i));
      exp_q.push_back(8'h40);
      hold(1'b0, 1'b1, 400, 1'b0);
      for (i = 0; i < 50 && exp_q.size() != 0; i++) @(posedge ref_clk_in);
      if (exp_q.size() != 0) failures++;
      finish_test();
   end
endmodule // tb_top
